// [design/bfs_pkg.sv]
// constants and carrier types of the breaker failure supervisor
package bfs_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_PHASE_LVL = 6'h04;
	localparam logic [5:0] OFS_RES_LVL = 6'h08;
	localparam logic [5:0] OFS_RETRIP_DLY = 6'h0C;
	localparam logic [5:0] OFS_FAIL_DLY = 6'h10;
	localparam logic [5:0] OFS_SIG_MASK = 6'h14;
	localparam logic [5:0] OFS_DO_MASK = 6'h18;
	localparam logic [5:0] OFS_STATUS = 6'h1C;
	localparam logic [5:0] OFS_SNAP = 6'h20;
	localparam int CTRL_FORCE_EN = 0;
	localparam int CTRL_RETRIP_EN = 1;
	localparam int CTRL_FORCE_LSB = 4;
	localparam int CTRL_RES_LSB = 8;
	localparam int CTRL_MODE_LSB = 12;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_F373;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
	localparam int PHASE_LVL_W = 13;
	localparam int RES_LVL_W = 16;
	localparam int DLY_W = 19;
	localparam int MEAS_W = 16;
	localparam int CMP_W = 24;
	localparam logic [12:0] PHASE_LVL_RESET = 13'h0014;
	localparam logic [15:0] RES_LVL_RESET = 16'h04B0;
	localparam logic [18:0] RETRIP_DLY_RESET = 19'h00014;
	localparam logic [18:0] FAIL_DLY_RESET = 19'h00028;
	localparam logic [23:0] PHASE_SCALE = 24'h00000A;
	localparam logic [23:0] RELEASE_PCT = 24'h000061;
	localparam logic [23:0] FULL_PCT = 24'h000064;
	localparam int STAT_START = 4;
	localparam int STAT_RETRIP = 5;
	localparam int STAT_FAIL = 6;
	localparam int STAT_BLOCKED = 7;
	localparam int STAT_CUR_PU = 8;
	localparam int STAT_DO_PU = 9;
	localparam int STAT_SIG_PU = 10;
	localparam int STAT_FAULT_LSB = 12;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CYCLE_TIME_MS = 5;
	localparam int CYCLE_CLKS = CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		MODE_CUR = 4'h0, MODE_DO = 4'h1, MODE_SIG = 4'h2, MODE_CUR_AND_DO = 4'h3,
		MODE_CUR_OR_DO = 4'h4, MODE_CUR_AND_SIG = 4'h5, MODE_CUR_OR_SIG = 4'h6,
		MODE_SIG_AND_DO = 4'h7, MODE_SIG_OR_DO = 4'h8, MODE_ANY = 4'h9,
		MODE_ALL = 4'hA
	} bfs_mode_type;
	typedef enum logic [2:0] {
		COND_NORMAL = 3'h0, COND_START = 3'h1, COND_RETRIP = 3'h2,
		COND_FAIL = 3'h3, COND_BLOCKED = 3'h4
	} bfs_cond_type;
	typedef enum logic [1:0] {
		RES_NONE = 2'h0, RES_ONE = 2'h1, RES_TWO = 2'h2, RES_COMPUTED = 2'h3
	} bfs_res_type;
	typedef struct packed {
		logic [2:0][MEAS_W-1:0] phase;
		logic [MEAS_W-1:0] residual_input_one;
		logic [MEAS_W-1:0] residual_input_two;
		logic [MEAS_W-1:0] computed_residual;
	} bfs_meas_type;
	typedef struct packed {
		logic start;
		logic second_trip;
		logic breaker_failure_output;
		logic blocked;
		logic [2:0] condition;
	} bfs_out_type;
endpackage

// [design/bfs_top.sv]
// breaker failure supervisor: pick-up, blocking, delay timers, axi4-lite registers
// Functional notes
// - selected trip events start countdown in signal modes
// - selected relay states start countdown in output modes
// - test forcing overrides state, selector defaults normal
// - three phases share threshold, residual own threshold
// - current pick-up releases below 97 percent
// - residual source: none, one, two, computed
// - eleven operating modes, default current only
// - phase threshold 0.01 steps, default 0.20
// - residual threshold 0.001 steps, default 1.200
// - start only while blocking inactive
// - signal pick-up in same evaluation cycle
// - read-only five-value condition code
// - blocking sampled at start of each cycle
// - blocked pick-up asserts blocked, no timers
// - blocking during start drops start, releases timers
// - entering blocked gives event with currents, fault
// - one pick-up starts both timers together
// - retrip disable silences retrip output
// - retrip after delay, 5 ms resolution
// - failure output after failure delay
// - counters reset once current falls below
// - current and output mode holds until output
// - inputs refreshed on 5 ms time base
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module bfs_top import bfs_pkg::*; #(
	parameter int CYCLE_CLKS_P = CYCLE_CLKS
) (
	input logic aclk,
	input logic aresetn,
	input logic [ADDR_W-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [ADDR_W-1:0] s_axi_araddr,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input bfs_meas_type meas_in,
	input logic [31:0] trip_signal_in,
	input logic [31:0] relay_state_in,
	input logic block_in,
	output bfs_out_type status_out,
	output logic block_event,
	output logic cycle_tick
);
	localparam int DIV_W = $clog2(CYCLE_CLKS_P + 1);

	logic [DIV_W-1:0] div_q;
	logic tick_q;
	logic eval_q;
	bfs_meas_type meas_q;
	logic [31:0] sig_q;
	logic [31:0] do_q;
	logic block_q;
	logic [31:0] ctrl_q;
	logic [PHASE_LVL_W-1:0] phase_lvl_q;
	logic [RES_LVL_W-1:0] res_lvl_q;
	logic [1:0][DLY_W-1:0] dly_q;
	logic [31:0] sig_mask_q;
	logic [31:0] do_mask_q;
	logic [3:0] ch_q;
	logic [3:0] ch_now;
	logic [3:0] ch_en;
	logic [3:0][CMP_W-1:0] ch_meas;
	logic [3:0][CMP_W-1:0] ch_thr;
	logic [3:0][MEAS_W-1:0] snap_q;
	logic [3:0] fault_q;
	logic [1:0][DLY_W-1:0] tcnt_q;
	logic [1:0] texp_q;
	logic cur_pu;
	logic do_pu;
	logic sig_pu;
	logic comb_pu;
	logic start_cond;
	logic run_cond;
	logic [2:0] pu_q;
	logic start_q;
	logic blocked_q;
	bfs_out_type real_out;
	bfs_out_type forced;
	bfs_out_type out_q;
	logic block_event_q;
	bfs_mode_type mode;
	bfs_res_type res_sel;
	logic retrip_en;
	logic [2:0] force_sel;

	assign mode = bfs_mode_type'(ctrl_q[CTRL_MODE_LSB +: 4]);
	assign res_sel = bfs_res_type'(ctrl_q[CTRL_RES_LSB +: 2]);
	assign retrip_en = ctrl_q[CTRL_RETRIP_EN];
	assign force_sel = ctrl_q[CTRL_FORCE_LSB +: 3];

	// program cycle divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == DIV_W'(CYCLE_CLKS_P - 1));
			if (div_q == DIV_W'(CYCLE_CLKS_P - 1)) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	// inputs and blocking are captured before the evaluation cycle reads them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meas_q <= '0;
			sig_q <= '0;
			do_q <= '0;
			block_q <= 1'b0;
			eval_q <= 1'b0;
		end else begin
			eval_q <= tick_q;
			if (tick_q) begin
				meas_q <= meas_in;
				sig_q <= trip_signal_in;
				do_q <= relay_state_in;
				block_q <= block_in;
			end
		end
	end

	// residual measurement source; continuous like the phase lanes, so one driver kind
	assign ch_meas[3] = (res_sel == RES_ONE) ? CMP_W'(meas_q.residual_input_one)
		: (res_sel == RES_TWO) ? CMP_W'(meas_q.residual_input_two)
		: (res_sel == RES_COMPUTED) ? CMP_W'(meas_q.computed_residual)
		: '0;
	assign ch_thr[3] = CMP_W'(res_lvl_q);
	assign ch_en[3] = (res_sel != RES_NONE);

	// per channel comparator with release hysteresis
	for (genvar i = 0; i < 4; i++) begin : g_ch
		logic over;
		logic under;
		if (i < 3) begin : g_phase
			assign ch_meas[i] = CMP_W'(meas_q.phase[i]);
			assign ch_thr[i] = CMP_W'(CMP_W'(phase_lvl_q) * PHASE_SCALE);
			assign ch_en[i] = 1'b1;
		end
		assign over = ch_meas[i] > ch_thr[i];
		// release point tied to the setting, not to the pick-up value
		assign under = CMP_W'(ch_meas[i] * FULL_PCT) < CMP_W'(ch_thr[i] * RELEASE_PCT);
		assign ch_now[i] = ch_en[i] & (over | (ch_q[i] & ~under));
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ch_q[i] <= 1'b0;
			end else if (eval_q) begin
				ch_q[i] <= ch_now[i];
			end
		end
	end

	assign cur_pu = |ch_now;
	assign sig_pu = |(sig_q & sig_mask_q);
	assign do_pu = |(do_q & do_mask_q);

	// pick-up combination per operating mode
	always_comb begin
		unique case (mode)
			MODE_CUR: comb_pu = cur_pu;
			MODE_DO: comb_pu = do_pu;
			MODE_SIG: comb_pu = sig_pu;
			MODE_CUR_AND_DO: comb_pu = cur_pu & do_pu;
			MODE_CUR_OR_DO: comb_pu = cur_pu | do_pu;
			MODE_CUR_AND_SIG: comb_pu = cur_pu & sig_pu;
			MODE_CUR_OR_SIG: comb_pu = cur_pu | sig_pu;
			MODE_SIG_AND_DO: comb_pu = sig_pu & do_pu;
			MODE_SIG_OR_DO: comb_pu = sig_pu | do_pu;
			MODE_ANY: comb_pu = cur_pu | do_pu | sig_pu;
			MODE_ALL: comb_pu = cur_pu & do_pu & sig_pu;
			default: comb_pu = 1'b0;
		endcase
	end

	// current alone raises start, the timers wait for the relay
	assign start_cond = (mode == MODE_CUR_AND_DO) ? cur_pu : comb_pu;
	assign run_cond = comb_pu & ~block_q;

	// retrip and failure timers share one pick-up
	for (genvar j = 0; j < 2; j++) begin : g_tmr
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tcnt_q[j] <= '0;
				texp_q[j] <= 1'b0;
			end else if (eval_q) begin
				if (!run_cond) begin
					tcnt_q[j] <= '0;
					texp_q[j] <= 1'b0;
				end else begin
					if (tcnt_q[j] != {DLY_W{1'b1}}) begin
						tcnt_q[j] <= tcnt_q[j] + 1'b1;
					end
					texp_q[j] <= (CMP_W'(tcnt_q[j]) + 1'b1) >= CMP_W'(dly_q[j]);
				end
			end
		end
	end

	// real outputs, updated once per program cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_q <= 1'b0;
			blocked_q <= 1'b0;
			pu_q <= '0;
			fault_q <= '0;
			snap_q <= '0;
			block_event_q <= 1'b0;
		end else begin
			block_event_q <= 1'b0;
			if (eval_q) begin
				start_q <= start_cond & ~block_q;
				blocked_q <= start_cond & block_q;
				pu_q <= {sig_pu, do_pu, cur_pu};
				if (start_cond & block_q & ~blocked_q) begin
					block_event_q <= 1'b1;
					fault_q <= ch_now;
					for (int k = 0; k < 4; k++) begin
						snap_q[k] <= ch_meas[k][MEAS_W-1:0];
					end
				end
			end
		end
	end

	always_comb begin
		real_out.start = start_q;
		real_out.second_trip = start_q & texp_q[0] & retrip_en;
		real_out.breaker_failure_output = start_q & texp_q[1];
		real_out.blocked = blocked_q;
		if (blocked_q) begin
			real_out.condition = COND_BLOCKED;
		end else if (real_out.breaker_failure_output) begin
			real_out.condition = COND_FAIL;
		end else if (real_out.second_trip) begin
			real_out.condition = COND_RETRIP;
		end else if (start_q) begin
			real_out.condition = COND_START;
		end else begin
			real_out.condition = COND_NORMAL;
		end
	end

	// forced states for commissioning; codes above four act as normal
	always_comb begin
		forced.condition = (force_sel > 3'(COND_BLOCKED)) ? COND_NORMAL : force_sel;
		forced.start = (forced.condition == COND_START) | (forced.condition == COND_RETRIP)
			| (forced.condition == COND_FAIL);
		forced.second_trip = (forced.condition == COND_RETRIP) & retrip_en;
		forced.breaker_failure_output = (forced.condition == COND_FAIL);
		forced.blocked = (forced.condition == COND_BLOCKED);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= '0;
		end else begin
			out_q <= ctrl_q[CTRL_FORCE_EN] ? forced : real_out;
		end
	end

	assign status_out = out_q;
	assign block_event = block_event_q;
	assign cycle_tick = eval_q;

	// axi4-lite write path
	logic aw_got_q;
	logic w_got_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [31:0] wr_data_q;
	logic [3:0] wr_strb_q;
	logic do_write;
	logic aw_got_d;
	logic w_got_d;
	logic bvalid_d;
	logic wr_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction

	assign do_write = aw_got_q & w_got_q & ~bvalid_q;
	always_comb begin
		aw_got_d = (aw_got_q | (s_axi_awvalid & awready_q)) & ~do_write;
		w_got_d = (w_got_q | (s_axi_wvalid & wready_q)) & ~do_write;
		bvalid_d = (bvalid_q & ~s_axi_bready) | do_write;
		unique case (wr_addr_q)
			OFS_CTRL, OFS_PHASE_LVL, OFS_RES_LVL, OFS_RETRIP_DLY,
			OFS_FAIL_DLY, OFS_SIG_MASK, OFS_DO_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			wr_addr_q <= '0;
			wr_data_q <= '0;
			wr_strb_q <= '0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			bvalid_q <= bvalid_d;
			awready_q <= ~aw_got_d & ~bvalid_d & ~do_write;
			wready_q <= ~w_got_d & ~bvalid_d & ~do_write;
			if (s_axi_awvalid & awready_q) begin
				wr_addr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
			end
			if (s_axi_wvalid & wready_q) begin
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// settings registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			phase_lvl_q <= PHASE_LVL_RESET;
			res_lvl_q <= RES_LVL_RESET;
			dly_q[0] <= RETRIP_DLY_RESET;
			dly_q[1] <= FAIL_DLY_RESET;
			sig_mask_q <= '0;
			do_mask_q <= '0;
		end else if (do_write) begin
			unique case (wr_addr_q)
				OFS_CTRL: ctrl_q <= merge(ctrl_q, wr_data_q, wr_strb_q) & CTRL_WMASK;
				OFS_PHASE_LVL: phase_lvl_q <= PHASE_LVL_W'(merge(32'(phase_lvl_q),
					wr_data_q, wr_strb_q));
				OFS_RES_LVL: res_lvl_q <= RES_LVL_W'(merge(32'(res_lvl_q),
					wr_data_q, wr_strb_q));
				OFS_RETRIP_DLY: dly_q[0] <= DLY_W'(merge(32'(dly_q[0]),
					wr_data_q, wr_strb_q));
				OFS_FAIL_DLY: dly_q[1] <= DLY_W'(merge(32'(dly_q[1]),
					wr_data_q, wr_strb_q));
				OFS_SIG_MASK: sig_mask_q <= merge(sig_mask_q, wr_data_q, wr_strb_q);
				OFS_DO_MASK: do_mask_q <= merge(do_mask_q, wr_data_q, wr_strb_q);
				default: ;
			endcase
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// axi4-lite read path
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic ar_take;
	logic rvalid_d;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [ADDR_W-1:0] rd_addr;

	assign ar_take = s_axi_arvalid & arready_q;
	assign rvalid_d = (rvalid_q & ~s_axi_rready) | ar_take;
	assign rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};

	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (rd_addr)
			OFS_CTRL: rd_word = ctrl_q;
			OFS_PHASE_LVL: rd_word = 32'(phase_lvl_q);
			OFS_RES_LVL: rd_word = 32'(res_lvl_q);
			OFS_RETRIP_DLY: rd_word = 32'(dly_q[0]);
			OFS_FAIL_DLY: rd_word = 32'(dly_q[1]);
			OFS_SIG_MASK: rd_word = sig_mask_q;
			OFS_DO_MASK: rd_word = do_mask_q;
			OFS_STATUS: begin
				rd_word[2:0] = out_q.condition;
				rd_word[STAT_START] = out_q.start;
				rd_word[STAT_RETRIP] = out_q.second_trip;
				rd_word[STAT_FAIL] = out_q.breaker_failure_output;
				rd_word[STAT_BLOCKED] = out_q.blocked;
				rd_word[STAT_SIG_PU:STAT_CUR_PU] = pu_q;
				rd_word[STAT_FAULT_LSB +: 4] = fault_q;
			end
			default: begin
				if (rd_addr[ADDR_W-1:4] == OFS_SNAP[ADDR_W-1:4]) begin
					rd_word = 32'(snap_q[rd_addr[3:2]]);
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			arready_q <= ~rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule

// [tb/bfs_front.sv]
// front end model: measurements, trip signals, relay states and blocking
`timescale 1ns/1ps
module bfs_front import bfs_pkg::*; (
	input logic aclk,
	input logic cycle_tick,
	input bfs_meas_type meas_next,
	input logic [31:0] sig_next,
	input logic [31:0] rel_next,
	input logic blk_next,
	output bfs_meas_type meas_in,
	output logic [31:0] trip_signal_in,
	output logic [31:0] relay_state_in,
	output logic block_in
);
	initial begin
		meas_in = '0;
		trip_signal_in = 32'h0;
		relay_state_in = 32'h0;
		block_in = 1'b0;
	end
	// refreshed once per evaluation, so blocking lands a full cycle late
	always @(posedge aclk) begin
		if (cycle_tick) begin
			meas_in <= meas_next;
			trip_signal_in <= sig_next;
			relay_state_in <= rel_next;
			block_in <= blk_next;
		end
	end
endmodule

// [tb/bfs_chk.sv]
// port checker for the breaker failure supervisor
`timescale 1ns/1ps
module bfs_chk import bfs_pkg::*; (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input bfs_out_type status_out,
	input logic block_event,
	input logic cycle_tick
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	AST_B_TIME: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not on second edge");
	AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during read data");
	AST_START_BLK: assert property (!(status_out.start && status_out.blocked))
		else $error("start and blocked together");
	AST_COND_RANGE: assert property (status_out.condition <= 3'h4)
		else $error("condition code out of range");
	AST_BLK_QUIET: assert property (status_out.blocked |-> !status_out.second_trip)
		else $error("retrip while blocked");
	AST_BEV_PULSE: assert property (block_event |=> !block_event)
		else $error("block event longer than one cycle");
	AST_BEV_STATE: assert property (block_event |-> ##[0:2] status_out.blocked)
		else $error("block event without blocked state");
	AST_TICK_GAP: assert property (cycle_tick |=> !cycle_tick [*8])
		else $error("evaluation cycles too close");
endmodule
bind bfs_top bfs_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.status_out, .block_event, .cycle_tick);

// [tb/testbench.sv]
// register-level test sequence for the breaker failure supervisor
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module testbench import bfs_pkg::*;;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, block_in, block_event, cycle_tick, bn;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, trip_signal_in, relay_state_in, sn, rn;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	bfs_meas_type meas_in, mn;
	bfs_out_type status_out;
	int n_errors, checks_done, nbev;
	bfs_top #(.CYCLE_CLKS_P(20)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.meas_in, .trip_signal_in, .relay_state_in, .block_in, .status_out,
		.block_event, .cycle_tick);
	bfs_front i_front (.aclk, .cycle_tick, .meas_next(mn), .sig_next(sn),
		.rel_next(rn), .blk_next(bn), .meas_in, .trip_signal_in, .relay_state_in,
		.block_in);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) if (block_event) nbev <= nbev + 1;
	task automatic end_of_test;
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bound(input int i);
		if (i >= 100) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		bound(i);
		`CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		bound(i);
		`CHK("rresp", er, s_axi_rresp)
		if (er == RESP_OKAY) `CHK("rdata", e, s_axi_rdata)
	endtask
	// waits n evaluations, then lets status settle
	task automatic ev(input int n);
		int i;
		for (int k = 0; k < n; k++) begin
			for (i = 0; i < 100 && !cycle_tick; i++) @(posedge aclk);
			bound(i);
			@(posedge aclk);
		end
		repeat (2) @(posedge aclk);
	endtask
	task automatic sts(input logic [6:0] e);
		`CHK("status", e, status_out)
	endtask
	function automatic logic pu(input int m, input logic c, d, s);
		case (m)
			0, 3: return c;
			1: return d;
			2: return s;
			4: return c | d;
			5: return c & s;
			6: return c | s;
			7: return s & d;
			8: return s | d;
			9: return c | d | s;
			default: return c & d & s;
		endcase
	endfunction
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sn, rn} = '0;
		s_axi_wstrb = 4'hF;
		mn = '0;
		bn = 1'b0;
		n_errors = 0;
		checks_done = 0;
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
		rd(OFS_PHASE_LVL, 32'h0000_0014, RESP_OKAY);
		rd(OFS_RES_LVL, 32'h0000_04B0, RESP_OKAY);
		rd(OFS_RETRIP_DLY, 32'h0000_0014, RESP_OKAY);
		rd(OFS_FAIL_DLY, 32'h0000_0028, RESP_OKAY);
		rd(OFS_SIG_MASK, 32'h0000_0000, RESP_OKAY);
		rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
		rd(6'h30, 32'h0000_0000, RESP_SLVERR);
		wr(6'h3C, 32'h0000_0001, RESP_SLVERR);
		wr(OFS_RETRIP_DLY, 32'h0000_0002, RESP_OKAY);
		wr(OFS_FAIL_DLY, 32'h0000_0004, RESP_OKAY);
		mn.phase[1] <= 16'h00C9;
		ev(2);
		sts(7'h41);
		ev(1);
		sts(7'h62);
		ev(1);
		sts(7'h62);
		ev(1);
		sts(7'h73);
		mn.phase[1] <= 16'h00C3;
		ev(2);
		sts(7'h73);
		mn.phase[1] <= 16'h00C1;
		ev(2);
		sts(7'h00);
		wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		mn.phase[1] <= 16'h00C9;
		ev(3);
		sts(7'h41);
		ev(2);
		sts(7'h53);
		bn <= 1'b1;
		ev(2);
		sts(7'h0C);
		`CHK("block events", 1, nbev)
		rd(OFS_SNAP + 6'h04, 32'h0000_00C9, RESP_OKAY);
		rd(OFS_STATUS, 32'h0000_2184, RESP_OKAY);
		ev(4);
		sts(7'h0C);
		bn <= 1'b0;
		ev(2);
		sts(7'h41);
		mn.phase[1] <= 16'h0000;
		for (int src = 0; src < 4; src++) begin
			wr(OFS_CTRL, {22'h0, src[1:0], 8'h02}, RESP_OKAY);
			for (int h = 1; h < 4; h++) begin
				mn.residual_input_one <= (h == 1) ? 16'h04B1 : 16'h0000;
				mn.residual_input_two <= (h == 2) ? 16'h04B1 : 16'h0000;
				mn.computed_residual <= (h == 3) ? 16'h04B1 : 16'h0000;
				ev(2);
				`CHK("residual start", src == h, status_out.start)
			end
		end
		mn <= '0;
		wr(OFS_SIG_MASK, 32'h0000_0001, RESP_OKAY);
		wr(OFS_DO_MASK, 32'h0000_0001, RESP_OKAY);
		for (int m = 0; m < 11; m++) begin
			wr(OFS_CTRL, {16'h0, m[3:0], 12'h002}, RESP_OKAY);
			for (int p = 0; p < 8; p++) begin
				mn.phase[0] <= p[0] ? 16'h00C9 : 16'h0000;
				// bit 1 is never enabled, so it must stay without effect
				rn <= {30'h0, 1'b1, p[1]};
				sn <= {30'h0, 1'b1, p[2]};
				ev(2);
				`CHK("mode start", pu(m, p[0], p[1], p[2]), status_out.start)
			end
		end
		wr(OFS_CTRL, 32'h0000_3002, RESP_OKAY);
		mn.phase[0] <= 16'h00C9;
		rn <= 32'h0000_0000;
		ev(6);
		sts(7'h41);
		rn <= 32'h0000_0001;
		ev(3);
		sts(7'h62);
		for (int f = 0; f < 5; f++) begin
			wr(OFS_CTRL, {24'h0, 1'b0, f[2:0], 4'h3}, RESP_OKAY);
			repeat (3) @(posedge aclk);
			`CHK("forced condition", f[2:0], status_out.condition)
		end
		end_of_test();
	end
endmodule
